/* acs_pkg.sv */
/*
   Package for the conversion sequencer: timing counts, enumerations and the
   packed carriers used by the sequencer; its clock divider takes only the divider widths.
   Assumes a single system clock; nothing here is clock dependent.
*/
package acs_pkg;
   // Result width of one conversion
   localparam int ACS_RES_W = 12;
   // Width of the accumulated sum
   localparam int ACS_SUM_W = 16;
   // Sampling phase length in conversion clock periods
   localparam logic [4:0] ACS_SAMPLE_CYC = 5'h04;
   // Total conversion length in conversion clock periods
   localparam logic [4:0] ACS_TOTAL_CYC = 5'h10;
   // Conversions summed in accumulation mode
   localparam logic [4:0] ACS_ACCUM_CNT = 5'h10;
   // Divider select width
   localparam int ACS_DIV_W = 3;
   // Divider counter width, enough for divide by 128
   localparam int ACS_DCNT_W = 7;
   // Reset value of result bytes
   localparam logic [7:0] ACS_RESULT_RST = 8'h00;

   // Sequencer phases
   typedef enum logic [1:0] {ACS_IDLE, ACS_SAMPLE, ACS_CONVERT} acs_phase_t;

   // Software control bits gathered together
   typedef struct packed {
      logic start;                         // Start bit level
      logic power_enable;                  // Converter power enable
      logic accumulate;                    // Accumulation mode
      logic align;                         // Result alignment
      logic [ACS_DIV_W-1:0] div_select;    // Conversion clock divider select
   } acs_ctrl_t;

   // Result register pair
   typedef struct packed {
      logic [7:0] high_byte;               // Result high byte
      logic [7:0] low_byte;                // Result low byte
   } acs_result_t;
endpackage

/* acs_clock_divider.sv */
/*
   Power-of-two divider making the conversion clock enable pulse.
   Assumes a synchronous active-low reset and a run input that restarts it.
*/
`timescale 1ns/100ps
`default_nettype none
module acs_clock_divider
   import acs_pkg::*;
(
   input wire logic clk_in,                        // System clock
   input wire logic rst_b_in,                      // Synchronous reset, low
   input wire logic run_in,                        // Count while high
   input wire logic [ACS_DIV_W-1:0] select_in,     // Divide by 2**select
   output logic tick_out                           // One-cycle enable pulse
);
   // All divider state
   typedef struct packed {
      logic [ACS_DCNT_W-1:0] count;                // Cycles since last tick
      logic tick;                                  // Registered pulse
   } acs_div_state_t;

   acs_div_state_t state_reg;
   acs_div_state_t state_next;
   logic [ACS_DCNT_W-1:0] last_count;              // Terminal count

   // Terminal count equals divisor minus one
   always_comb begin
      last_count = ACS_DCNT_W'((8'h01 << select_in) - 8'h01);
   end

   // Next divider state
   always_comb begin
      state_next = state_reg;
      state_next.tick = 1'b0;
      if (!run_in) begin
         // Held in restart while idle
         state_next.count = '0;
      end else if (state_reg.count >= last_count) begin
         // Divisor reached, emit a tick
         state_next.count = '0;
         state_next.tick = 1'b1;
      end else begin
         state_next.count = state_reg.count + 1'b1;
      end
   end

   // State register
   always_ff @(posedge clk_in) begin
      if (!rst_b_in) begin
         state_reg <= '0;
      end else begin
         state_reg <= state_next;
      end
   end

   assign tick_out = state_reg.tick;
endmodule
`default_nettype wire

/* acs_sequencer.sv */
/*
   Conversion sequencer for a 12-bit successive-approximation converter:
   start pulse detection, sample and convert phases, busy and interrupt
   request flags, accumulation mode and result formatting.
   Assumes the analog core returns its code on ANALOG_CODE_IN in the
   system clock domain, valid when a conversion phase ends, and that
   the interrupt controller takes IRQ_REQ_OUT as a one-cycle pulse.
*/
// Function
// - Start on start bit high then low
// - Hardware sets busy on start
// - Hardware clears busy when finished
// - Completion sets interrupt request flag
// - Request raised when both enables set
// - Conversion clock is system clock over 2**select
// - Analog powered only while enable high
// - Sampling lasts four conversion clocks
// - Twelve conversion clocks, sixteen total
// - Single mode gives one 12-bit result
// - Accumulate mode sums sixteen conversions
// - Store 16-bit sum after sixteenth conversion
// - Align bit picks single result layout
// - Disabling keeps result registers unchanged
`timescale 1ns/100ps
`default_nettype none
module acs_sequencer
   import acs_pkg::*;
(
   input wire logic CLK_IN,                           // System clock, 20 MHz
   input wire logic RST_B_IN,                         // Synchronous reset, low
   input wire logic CONV_START_IN,                    // Start control bit
   input wire logic CONV_POWER_ENABLE_IN,             // Converter enable bit
   input wire logic ACCUMULATE_MODE_SELECT_IN,        // Accumulation mode bit
   input wire logic RESULT_ALIGN_SELECT_IN,           // Result format bit
   input wire logic [ACS_DIV_W-1:0] CONV_CLOCK_DIVIDER_SELECT_IN, // Divider select
   input wire logic CONV_INT_ENABLE_IN,               // Converter interrupt enable
   input wire logic GLOBAL_INT_ENABLE_IN,             // Global interrupt enable
   input wire logic INT_FLAG_CLEAR_IN,                // Software clears request flag
   input wire logic [ACS_RES_W-1:0] ANALOG_CODE_IN,   // Code from analog core
   output logic CONV_BUSY_FLAG_OUT,                   // Busy flag
   output logic INT_REQUEST_FLAG_OUT,                 // Sticky request flag
   output logic IRQ_REQ_OUT,                          // Interrupt request pulse
   output logic ANALOG_POWER_OUT,                     // Analog core power
   output logic ANALOG_SAMPLE_OUT,                    // Analog sampling phase
   output logic [7:0] RESULT_HIGH_BYTE_OUT,           // Result high byte
   output logic [7:0] RESULT_LOW_BYTE_OUT             // Result low byte
);
   // All sequencer state
   typedef struct packed {
      acs_ctrl_t ctrl;                  // Registered control inputs
      logic start_seen;                 // Start bit went high
      acs_phase_t phase;                // Current phase
      logic [4:0] clk_count;            // Conversion clocks in this conversion
      logic [4:0] conv_count;           // Conversions done in accumulation
      logic [ACS_SUM_W-1:0] sum;        // Running sum
      logic busy;                       // Busy flag
      logic int_flag;                   // Interrupt request flag
      logic irq;                        // Interrupt request pulse
      acs_result_t result;              // Result register pair
      logic sample;                     // Sampling phase output
   } acs_state_t;

   // Registered state and its next value
   acs_state_t state_reg;
   acs_state_t state_next;
   logic conv_tick;                     // Conversion clock enable
   logic running;                       // Divider run enable
   logic [ACS_SUM_W-1:0] sum_plus;      // Sum with the new code

   // Divider runs only inside a sequence
   assign running = (state_reg.phase != ACS_IDLE);

   // Conversion clock enable generator
   // Select comes from the registered copy, so a change takes effect one cycle later, mid-count if running
   acs_clock_divider acs_clock_divider_i (
      .clk_in(CLK_IN),
      .rst_b_in(RST_B_IN),
      .run_in(running),
      .select_in(state_reg.ctrl.div_select),
      .tick_out(conv_tick)
   );

   // Formats a single result by alignment
   function automatic acs_result_t align_result(input logic [ACS_RES_W-1:0] code, input logic align);
      acs_result_t r;
      // Unused nibble reads as zero
      if (!align) begin
         r.high_byte = code[11:4];
         r.low_byte = {4'h0, code[3:0]};
      end else begin
         r.high_byte = {4'h0, code[11:8]};
         r.low_byte = code[7:0];
      end
      return r;
   endfunction

   // Accumulated sum including the current code
   // Sixteen 12-bit codes cannot overflow sixteen bits
   assign sum_plus = state_reg.sum + ACS_SUM_W'(ANALOG_CODE_IN);

   // Next state
   always_comb begin
      state_next = state_reg;
      state_next.irq = 1'b0;
      state_next.ctrl.start = CONV_START_IN;
      state_next.ctrl.power_enable = CONV_POWER_ENABLE_IN;
      state_next.ctrl.accumulate = ACCUMULATE_MODE_SELECT_IN;
      state_next.ctrl.align = RESULT_ALIGN_SELECT_IN;
      state_next.ctrl.div_select = CONV_CLOCK_DIVIDER_SELECT_IN;
      // Software clear of the request flag
      if (INT_FLAG_CLEAR_IN) begin
         state_next.int_flag = 1'b0;
      end
      // Remember a rising start bit; a level alone does nothing
      if (state_reg.ctrl.start && !state_reg.start_seen) begin
         state_next.start_seen = 1'b1;
      end
      if (!state_reg.ctrl.power_enable) begin
         // Converter off: abort, results kept
         // Flag untouched: an aborted sequence raises no request
         // Sum and results left alone for a later read
         state_next.phase = ACS_IDLE;
         state_next.busy = 1'b0;
         state_next.start_seen = 1'b0;
         state_next.clk_count = '0;
         state_next.conv_count = '0;
      end else begin
         unique case (state_reg.phase)
            ACS_IDLE: begin
               // Falling start after a rise begins a conversion
               // A rise seen while busy is kept and fires here
               if (state_reg.start_seen && !state_reg.ctrl.start) begin
                  state_next.start_seen = 1'b0;
                  state_next.phase = ACS_SAMPLE;
                  state_next.busy = 1'b1;
                  state_next.clk_count = '0;
                  state_next.conv_count = '0;
                  state_next.sum = '0;
               end
            end
            ACS_SAMPLE: begin
               // Sampling for four conversion clocks
               // Divider keeps running across the phase change
               if (conv_tick) begin
                  state_next.clk_count = state_reg.clk_count + 5'h01;
                  if (state_reg.clk_count + 5'h01 == ACS_SAMPLE_CYC) begin
                     state_next.phase = ACS_CONVERT;
                  end
               end
            end
            ACS_CONVERT: begin
               // Conversion ends at sixteen conversion clocks
               // Analog code is valid in the cycle the phase ends
               if (conv_tick) begin
                  state_next.clk_count = state_reg.clk_count + 5'h01;
                  if (state_reg.clk_count + 5'h01 == ACS_TOTAL_CYC) begin
                     state_next.clk_count = '0;
                     if (!state_reg.ctrl.accumulate) begin
                        // Single conversion result
                        state_next.result = align_result(ANALOG_CODE_IN, state_reg.ctrl.align);
                        state_next.phase = ACS_IDLE;
                        state_next.busy = 1'b0;
                        state_next.int_flag = 1'b1;
                        // Pulse gated by both enables at completion
                        state_next.irq = CONV_INT_ENABLE_IN && GLOBAL_INT_ENABLE_IN;
                     end else if (state_reg.conv_count + 5'h01 == ACS_ACCUM_CNT) begin
                        // Sixteenth conversion: store the sum
                        state_next.result.high_byte = sum_plus[15:8];
                        state_next.result.low_byte = sum_plus[7:0];
                        state_next.sum = sum_plus;
                        state_next.phase = ACS_IDLE;
                        state_next.busy = 1'b0;
                        state_next.int_flag = 1'b1;
                        // One pulse only, after the final sum
                        state_next.irq = CONV_INT_ENABLE_IN && GLOBAL_INT_ENABLE_IN;
                     end else begin
                        // Next conversion, busy held
                        state_next.sum = sum_plus;
                        state_next.conv_count = state_reg.conv_count + 5'h01;
                        state_next.phase = ACS_SAMPLE;
                     end
                  end
               end
            end
            default: begin
               // Illegal phase code: fall back to idle
               state_next.phase = ACS_IDLE;
               state_next.busy = 1'b0;
               state_next.clk_count = '0;
            end
         endcase
      end
      // Sampling output registered together with the phase
      state_next.sample = (state_next.phase == ACS_SAMPLE);
   end

   // State register
   // Reset branch loads constants only
   always_ff @(posedge CLK_IN) begin
      if (!RST_B_IN) begin
         state_reg <= '0;
         state_reg.phase <= ACS_IDLE;
         state_reg.result <= {ACS_RESULT_RST, ACS_RESULT_RST};
      end else begin
         state_reg <= state_next;
      end
   end

   // Outputs straight from flip-flops
   // Every output is a register bit or a field of one
   assign CONV_BUSY_FLAG_OUT = state_reg.busy;
   assign INT_REQUEST_FLAG_OUT = state_reg.int_flag;
   assign IRQ_REQ_OUT = state_reg.irq;
   assign ANALOG_POWER_OUT = state_reg.ctrl.power_enable;
   assign ANALOG_SAMPLE_OUT = state_reg.sample;
   assign RESULT_HIGH_BYTE_OUT = state_reg.result.high_byte;
   assign RESULT_LOW_BYTE_OUT = state_reg.result.low_byte;
endmodule
`default_nettype wire

/* acs_sequencer_props.sv */
/* Checker for acs_sequencer: flag, request, timing and result relations.
   Assumes one clock and the synchronous active-low reset of the design. */
`timescale 1ns/100ps
`default_nettype none
module acs_sequencer_props
   import acs_pkg::*;
(
   input wire logic CLK_IN,
   input wire logic RST_B_IN,
   input wire logic CONV_START_IN,
   input wire logic CONV_POWER_ENABLE_IN,
   input wire logic ACCUMULATE_MODE_SELECT_IN,
   input wire logic [ACS_DIV_W-1:0] CONV_CLOCK_DIVIDER_SELECT_IN,
   input wire logic CONV_INT_ENABLE_IN,
   input wire logic GLOBAL_INT_ENABLE_IN,
   input wire logic CONV_BUSY_FLAG_OUT,
   input wire logic INT_REQUEST_FLAG_OUT,
   input wire logic IRQ_REQ_OUT,
   input wire logic ANALOG_POWER_OUT,
   input wire logic ANALOG_SAMPLE_OUT,
   input wire logic [7:0] RESULT_HIGH_BYTE_OUT,
   input wire logic [7:0] RESULT_LOW_BYTE_OUT
);
   // Cycles spent busy and sampling, and the busy length the mode asks for
   logic [15:0] busy_cnt_reg, smp_cnt_reg, exp_len;
   assign exp_len = (ACCUMULATE_MODE_SELECT_IN ? 16'h0100 : 16'h0010) << CONV_CLOCK_DIVIDER_SELECT_IN;
   // Counters clear whenever their phase is not active
   always_ff @(posedge CLK_IN) begin
      busy_cnt_reg <= CONV_BUSY_FLAG_OUT ? busy_cnt_reg + 16'h0001 : 16'h0000;
      smp_cnt_reg <= ANALOG_SAMPLE_OUT ? smp_cnt_reg + 16'h0001 : 16'h0000;
   end
   default clocking @(posedge CLK_IN); endclocking
   default disable iff (!RST_B_IN);
   property p_start; $fell(CONV_START_IN) && CONV_POWER_ENABLE_IN && !CONV_BUSY_FLAG_OUT |-> ##[1:4] CONV_BUSY_FLAG_OUT; endproperty
   a_start: assert property (p_start) else $error("busy did not follow start pulse");
   property p_start_low; $rose(CONV_BUSY_FLAG_OUT) |-> !CONV_START_IN && ANALOG_SAMPLE_OUT; endproperty
   a_start_low: assert property (p_start_low) else $error("busy rose with start high or no sampling");
   property p_flag_end; $fell(CONV_BUSY_FLAG_OUT) && $past(CONV_POWER_ENABLE_IN) && $past(CONV_POWER_ENABLE_IN, 2) |-> INT_REQUEST_FLAG_OUT; endproperty
   a_flag_end: assert property (p_flag_end) else $error("completion without request flag");
   property p_flag_cause; $rose(INT_REQUEST_FLAG_OUT) |-> $fell(CONV_BUSY_FLAG_OUT); endproperty
   a_flag_cause: assert property (p_flag_cause) else $error("request flag set while busy");
   property p_irq_on; $rose(INT_REQUEST_FLAG_OUT) && $past(CONV_INT_ENABLE_IN) && $past(GLOBAL_INT_ENABLE_IN) |-> IRQ_REQ_OUT; endproperty
   a_irq_on: assert property (p_irq_on) else $error("enabled completion gave no request pulse");
   property p_irq_gate; IRQ_REQ_OUT |-> $rose(INT_REQUEST_FLAG_OUT) && $past(CONV_INT_ENABLE_IN) && $past(GLOBAL_INT_ENABLE_IN); endproperty
   a_irq_gate: assert property (p_irq_gate) else $error("request pulse without cause");
   property p_power; 1'b1 |=> ANALOG_POWER_OUT == $past(CONV_POWER_ENABLE_IN); endproperty
   a_power: assert property (p_power) else $error("analog power does not follow enable");
   property p_abort; !CONV_POWER_ENABLE_IN |-> ##[0:2] !CONV_BUSY_FLAG_OUT; endproperty
   a_abort: assert property (p_abort) else $error("busy stayed up while disabled");
   property p_hold; !$rose(INT_REQUEST_FLAG_OUT) |-> $stable({RESULT_HIGH_BYTE_OUT, RESULT_LOW_BYTE_OUT}); endproperty
   a_hold: assert property (p_hold) else $error("result changed outside completion");
   property p_busy_len; $rose(INT_REQUEST_FLAG_OUT) |-> busy_cnt_reg >= exp_len && busy_cnt_reg <= exp_len + (exp_len >> 2) + 16'h0003; endproperty
   a_busy_len: assert property (p_busy_len) else $error("busy length wrong");
   property p_smp_len; $fell(ANALOG_SAMPLE_OUT) && CONV_POWER_ENABLE_IN |-> smp_cnt_reg >= (16'h0004 << CONV_CLOCK_DIVIDER_SELECT_IN) && smp_cnt_reg <= (16'h0006 << CONV_CLOCK_DIVIDER_SELECT_IN); endproperty
   a_smp_len: assert property (p_smp_len) else $error("sampling length wrong");
   c_single: cover property ($rose(INT_REQUEST_FLAG_OUT) && !ACCUMULATE_MODE_SELECT_IN);
   c_accum: cover property ($rose(INT_REQUEST_FLAG_OUT) && ACCUMULATE_MODE_SELECT_IN);
   c_abort: cover property ($fell(CONV_BUSY_FLAG_OUT) && !CONV_POWER_ENABLE_IN);
endmodule
bind acs_sequencer acs_sequencer_props acs_sequencer_props_i (.CLK_IN(CLK_IN), .RST_B_IN(RST_B_IN),
   .CONV_START_IN(CONV_START_IN), .CONV_POWER_ENABLE_IN(CONV_POWER_ENABLE_IN),
   .ACCUMULATE_MODE_SELECT_IN(ACCUMULATE_MODE_SELECT_IN), .CONV_CLOCK_DIVIDER_SELECT_IN(CONV_CLOCK_DIVIDER_SELECT_IN),
   .CONV_INT_ENABLE_IN(CONV_INT_ENABLE_IN), .GLOBAL_INT_ENABLE_IN(GLOBAL_INT_ENABLE_IN),
   .CONV_BUSY_FLAG_OUT(CONV_BUSY_FLAG_OUT), .INT_REQUEST_FLAG_OUT(INT_REQUEST_FLAG_OUT), .IRQ_REQ_OUT(IRQ_REQ_OUT),
   .ANALOG_POWER_OUT(ANALOG_POWER_OUT), .ANALOG_SAMPLE_OUT(ANALOG_SAMPLE_OUT),
   .RESULT_HIGH_BYTE_OUT(RESULT_HIGH_BYTE_OUT), .RESULT_LOW_BYTE_OUT(RESULT_LOW_BYTE_OUT));
`default_nettype wire

/* acs_sequencer_bench.sv */
/* Testbench for acs_sequencer: drives the control bits and analog code
   and checks flags, request pulses and results.
   Assumes the checker is bound in its own file. */
`timescale 1ns/100ps
`default_nettype none
module acs_sequencer_bench
   import acs_pkg::*;
;
   // Stimulus, all given a value at time zero
   logic clk = 1'b0, rst_b = 1'b0, start = 1'b0, en = 1'b0, accum = 1'b0, align = 1'b0;
   logic cie = 1'b0, gie = 1'b0, clr = 1'b0;
   logic [ACS_DIV_W-1:0] sel = 3'h0;
   logic [ACS_RES_W-1:0] code = 12'h9E7;
   // Observed outputs and bookkeeping
   logic busy, flag, irq, power, smp;
   logic [7:0] hi, lo, irq_cnt = 8'h00;
   logic [15:0] keep;
   int n_errors = 0, num_checks = 0;
   // 20 MHz clock
   always #25 clk = ~clk;
   // Count request pulses
   always @(posedge clk) if (irq === 1'b1) irq_cnt <= irq_cnt + 8'h01;
   acs_sequencer acs_sequencer_i (.CLK_IN(clk), .RST_B_IN(rst_b), .CONV_START_IN(start),
      .CONV_POWER_ENABLE_IN(en), .ACCUMULATE_MODE_SELECT_IN(accum), .RESULT_ALIGN_SELECT_IN(align),
      .CONV_CLOCK_DIVIDER_SELECT_IN(sel), .CONV_INT_ENABLE_IN(cie), .GLOBAL_INT_ENABLE_IN(gie),
      .INT_FLAG_CLEAR_IN(clr), .ANALOG_CODE_IN(code), .CONV_BUSY_FLAG_OUT(busy),
      .INT_REQUEST_FLAG_OUT(flag), .IRQ_REQ_OUT(irq), .ANALOG_POWER_OUT(power),
      .ANALOG_SAMPLE_OUT(smp), .RESULT_HIGH_BYTE_OUT(hi), .RESULT_LOW_BYTE_OUT(lo));
   // Step to just after the next rising edge
   task tick;
      @(posedge clk);
      #1;
   endtask
   // Compare and count
   task chk(input logic [15:0] got, input logic [15:0] exp);
      num_checks++;
      if (got !== exp) begin
         $display("unexpected at %0t ns: got %h expected %h", $time, got, exp);
         n_errors++;
      end
   endtask
   // Verdict and end of run
   task finish_test;
      $display("checks %0d errors %0d", num_checks, n_errors);
      if (n_errors == 0 && num_checks > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   // Clear the flag, hold start high, drop it, wait for busy
   task begin_conv;
      int i;
      i = 0;
      @(posedge clk) clr <= 1'b1;
      @(posedge clk) clr <= 1'b0;
      @(posedge clk) start <= 1'b1;
      repeat (6) tick;
      chk(16'(busy), 16'h0000);
      @(posedge clk) start <= 1'b0;
      while (busy !== 1'b1 && i < 6) begin
         tick;
         i++;
      end
      chk(16'(busy), 16'h0001);
      chk(16'(smp), 16'h0001);
   endtask
   // Poll busy until it drops, bounded
   task end_conv;
      int i;
      i = 0;
      while (busy === 1'b1 && i < 40000) begin
         tick;
         i++;
      end
      chk(16'(busy), 16'h0000);
      chk(16'(flag), 16'h0001);
   endtask
   // Main sequence
   initial begin
      int s;
      logic [7:0] n;
      repeat (3) @(posedge clk);
      rst_b <= 1'b1;
      en <= 1'b1;
      // Settling time after power up
      repeat (8) tick;
      chk(16'(power), 16'h0001);
      // Every divider, both layouts, interrupt gating combinations
      for (s = 0; s < 8; s++) begin
         n = irq_cnt;
         @(posedge clk);
         sel <= s[2:0];
         align <= s[0];
         cie <= s[1];
         gie <= (s != 3);
         begin_conv;
         end_conv;
         chk({hi, lo}, s[0] ? {4'h0, code} : {code[11:4], 4'h0, code[3:0]});
         tick;
         chk(16'(irq_cnt - n), 16'(s[1] && s != 3));
      end
      // Sixteen summed conversions, one request
      n = irq_cnt;
      @(posedge clk);
      accum <= 1'b1;
      sel <= 3'h0;
      begin_conv;
      repeat (100) tick;
      chk(16'(busy), 16'h0001);
      end_conv;
      chk({hi, lo}, 16'(code) << 4);
      tick;
      chk(16'(irq_cnt - n), 16'h0001);
      // Disable in mid-conversion
      keep = {hi, lo};
      @(posedge clk);
      accum <= 1'b0;
      sel <= 3'h4;
      begin_conv;
      repeat (60) tick;
      @(posedge clk) en <= 1'b0;
      repeat (3) tick;
      chk(16'(busy), 16'h0000);
      chk(16'(flag), 16'h0000);
      chk(16'(power), 16'h0000);
      chk({hi, lo}, keep);
      finish_test;
   end
   // Watchdog: the run needs under 5000 cycles, this allows over twelve times that
   initial begin
      #3000000;
      n_errors++;
      finish_test;
   end
endmodule
`default_nettype wire
